/* File: pkg/vifc_pkg.sv */
// package for the video input format configuration block
// Summary of operation
// - interface control bit0 enables embedded-sync input, bit1 enables timing flag correction
// - configuration bit15 zero: settings reach working copies only at internal vsync
// - configuration bit13 inverts the chroma sample MSB written to memory
// - configuration bit12 swaps byte order of stored data words
// - configuration bit11 picks luma on even (0) or odd (1) pixel for 8-bit YCbCr
// - with embedded sync on, bit5 picks 8-bit (0) or 10-bit (1) samples
package vifc_pkg;
  localparam logic [11:0] VIFC_ADDR_IFCTL = 12'h000;
  localparam logic [11:0] VIFC_ADDR_CFG   = 12'h004;
  localparam int VIFC_BIT_INPUT_EN   = 0;
  localparam int VIFC_BIT_FLAG_CORR  = 1;
  localparam int VIFC_BIT_SAMPLE_W   = 5;
  localparam int VIFC_BIT_LUMA_POS   = 11;
  localparam int VIFC_BIT_BYTE_SWAP  = 12;
  localparam int VIFC_BIT_MSB_INV    = 13;
  localparam int VIFC_BIT_VSYNC_LC   = 15;
  localparam logic [31:0] VIFC_IFCTL_MASK = 32'h0000_0003;
  localparam logic [31:0] VIFC_CFG_MASK   = 32'h0000_B820;
  localparam logic [31:0] VIFC_RESET_VAL  = 32'h0000_0000;
  localparam logic [31:0] VIFC_ERR_DATA   = 32'h0000_0000;

  typedef struct packed {
    logic embedded_sync_input_enable;
    logic timing_flag_correction_enable;
    logic embedded_sync_sample_width;
    logic luma_pixel_position;
    logic stored_byte_swap;
    logic chroma_msb_invert;
  } vifc_settings_t;

  typedef struct packed {
    logic [15:0] data;
    logic        is_chroma;
    logic        valid;
  } vifc_sample_t;
endpackage

/* File: rtl/vifc_shadow.sv */
// working-copy latch for the function settings
`timescale 1ns/1ns
`default_nettype none
module vifc_shadow
  import vifc_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           vsync_latch_control,
  input  wire logic           internal_vsync,
  input  wire vifc_settings_t program_value,
  output var  vifc_settings_t working
);
  vifc_settings_t next_working;

  always_comb
  begin
    next_working = working;
    if (vsync_latch_control || internal_vsync)
    begin
      next_working = program_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      working <= '0;
    else
      working <= next_working;
  end

  a_latch_held: assert property (@(posedge pclk) disable iff (!presetn)
      (!vsync_latch_control && !internal_vsync) |=> $stable(working))
    else $error("working copy changed outside vsync while latched");
  a_latch_taken: assert property (@(posedge pclk) disable iff (!presetn)
      (vsync_latch_control || internal_vsync) |=> working == $past(program_value))
    else $error("working copy missed programmed value");
endmodule
`default_nettype wire

/* File: rtl/vifc_top.sv */
// configuration registers and stored-data formatting of the video input
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module vifc_top
  import vifc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        internal_vsync,
  input  wire vifc_sample_t in_sample,
  output vifc_sample_t     out_sample,
  output logic             embedded_sync_input_enable,
  output logic             timing_flag_correction_enable,
  output logic             embedded_sync_sample_width,
  output logic             luma_pixel_position
);
  logic [31:0]    embedded_sync_interface_control;
  logic [31:0]    capture_configuration;
  logic [31:0]    next_ifctl;
  logic [31:0]    next_cfg;
  logic [31:0]    next_prdata;
  logic           next_pslverr;
  logic           hit_ifctl;
  logic           hit_cfg;
  logic           access;
  vifc_settings_t program_value;
  vifc_settings_t working;
  vifc_sample_t   next_out;
  logic [15:0]    fmt;

  // zero-wait slave: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign access    = psel && penable;
  assign hit_ifctl = (paddr == VIFC_ADDR_IFCTL);
  assign hit_cfg   = (paddr == VIFC_ADDR_CFG);

  always_comb
  begin
    next_ifctl   = embedded_sync_interface_control;
    next_cfg     = capture_configuration;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (access && pwrite && hit_ifctl)
    begin
      next_ifctl = pwdata & VIFC_IFCTL_MASK;
    end
    if (access && pwrite && hit_cfg)
    begin
      next_cfg = pwdata & VIFC_CFG_MASK;
    end
    if (psel && !penable && !pwrite)
    begin
      if (hit_ifctl)
        next_prdata = embedded_sync_interface_control;
      else if (hit_cfg)
        next_prdata = capture_configuration;
      else
        next_prdata = VIFC_ERR_DATA;
    end
    if (psel && !penable)
    begin
      next_pslverr = !(hit_ifctl || hit_cfg);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      embedded_sync_interface_control <= VIFC_RESET_VAL;
      capture_configuration           <= VIFC_RESET_VAL;
      prdata                          <= VIFC_RESET_VAL;
      pslverr                         <= 1'b0;
    end
    else
    begin
      embedded_sync_interface_control <= next_ifctl;
      capture_configuration           <= next_cfg;
      prdata                          <= next_prdata;
      pslverr                         <= next_pslverr;
    end
  end

  // software must set vsync latch control first; hardware does not enforce it
  always_comb
  begin
    program_value.embedded_sync_input_enable =
      embedded_sync_interface_control[VIFC_BIT_INPUT_EN];
    program_value.timing_flag_correction_enable =
      embedded_sync_interface_control[VIFC_BIT_FLAG_CORR];
    program_value.embedded_sync_sample_width = capture_configuration[VIFC_BIT_SAMPLE_W];
    program_value.luma_pixel_position        = capture_configuration[VIFC_BIT_LUMA_POS];
    program_value.stored_byte_swap           = capture_configuration[VIFC_BIT_BYTE_SWAP];
    program_value.chroma_msb_invert          = capture_configuration[VIFC_BIT_MSB_INV];
  end

  vifc_shadow u_shadow (
    .pclk                (pclk),
    .presetn             (presetn),
    .vsync_latch_control (capture_configuration[VIFC_BIT_VSYNC_LC]),
    .internal_vsync      (internal_vsync),
    .program_value       (program_value),
    .working             (working)
  );

  assign embedded_sync_input_enable    = working.embedded_sync_input_enable;
  assign timing_flag_correction_enable = working.timing_flag_correction_enable;
  // width select only means anything while embedded sync is on
  assign embedded_sync_sample_width    = working.embedded_sync_input_enable
                                         & working.embedded_sync_sample_width;
  assign luma_pixel_position           = working.luma_pixel_position;

  // stored-data path: msb invert applies to the chroma byte, then optional swap
  always_comb
  begin
    fmt = in_sample.data;
    if (working.chroma_msb_invert && in_sample.is_chroma)
    begin
      fmt[7] = ~fmt[7];
    end
    if (working.stored_byte_swap)
    begin
      fmt = {fmt[7:0], fmt[15:8]};
    end
    next_out.data      = fmt;
    next_out.is_chroma = in_sample.is_chroma;
    next_out.valid     = in_sample.valid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_sample <= '0;
    else
      out_sample <= next_out;
  end

  a_ifctl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (embedded_sync_interface_control & ~VIFC_IFCTL_MASK) == 32'h0000_0000)
    else $error("reserved control bit set");
  a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && hit_cfg) |=> capture_configuration == ($past(pwdata) & VIFC_CFG_MASK))
    else $error("configuration write lost");
  a_msb_invert: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sample.is_chroma && working.chroma_msb_invert && !working.stored_byte_swap)
      |=> out_sample.data[7] != $past(in_sample.data[7]))
    else $error("chroma msb not inverted");
  a_byte_swap: assert property (@(posedge pclk) disable iff (!presetn)
      (working.stored_byte_swap && !working.chroma_msb_invert)
      |=> out_sample.data == {$past(in_sample.data[7:0]), $past(in_sample.data[15:8])})
    else $error("byte swap wrong");
  a_plain_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (!working.stored_byte_swap && !working.chroma_msb_invert)
      |=> out_sample.data == $past(in_sample.data))
    else $error("data altered without option");
  a_width_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !embedded_sync_input_enable |-> !embedded_sync_sample_width)
    else $error("sample width set while embedded sync off");
  // the register must be steady across the copy edge, else the copy lags one write
  a_enable_follow: assert property (@(posedge pclk) disable iff (!presetn)
      capture_configuration[VIFC_BIT_VSYNC_LC]
      ##1 (capture_configuration[VIFC_BIT_VSYNC_LC] && $stable(embedded_sync_interface_control))
      |-> embedded_sync_input_enable == embedded_sync_interface_control[VIFC_BIT_INPUT_EN])
    else $error("input enable does not follow register");
  a_luma_follow: assert property (@(posedge pclk) disable iff (!presetn)
      internal_vsync |=> luma_pixel_position == $past(capture_configuration[VIFC_BIT_LUMA_POS]))
    else $error("luma position not taken at vsync");

  // bus side: readback and error answer are launched by the setup cycle
  a_ifctl_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && hit_ifctl)
      |=> embedded_sync_interface_control == ($past(pwdata) & VIFC_IFCTL_MASK))
    else $error("control write lost");
  a_cfg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_configuration & ~VIFC_CFG_MASK) == 32'h0000_0000)
    else $error("reserved configuration bit set");
  a_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && !hit_ifctl && !hit_cfg)
      |=> $stable(embedded_sync_interface_control) && $stable(capture_configuration))
    else $error("unmapped write changed a register");
  a_read_ifctl: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_ifctl)
      |=> prdata == $past(embedded_sync_interface_control))
    else $error("control readback wrong");
  a_read_cfg: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_cfg)
      |=> prdata == $past(capture_configuration))
    else $error("configuration readback wrong");
  a_error_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable)
      |=> pslverr == !($past(hit_ifctl) || $past(hit_cfg)))
    else $error("error answer wrong");
  a_flag_follow: assert property (@(posedge pclk) disable iff (!presetn)
      capture_configuration[VIFC_BIT_VSYNC_LC]
      ##1 (capture_configuration[VIFC_BIT_VSYNC_LC] && $stable(embedded_sync_interface_control))
      |-> timing_flag_correction_enable == embedded_sync_interface_control[VIFC_BIT_FLAG_CORR])
    else $error("flag correction does not follow register");
  // while latched, level outputs may only move on the edge after a vsync pulse
  a_vsync_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!capture_configuration[VIFC_BIT_VSYNC_LC] && !internal_vsync)
      |=> $stable(luma_pixel_position) && $stable(timing_flag_correction_enable))
    else $error("setting moved outside vsync while latched");
  a_out_flags: assert property (@(posedge pclk) disable iff (!presetn)
      in_sample.valid |=> out_sample.valid && out_sample.is_chroma == $past(in_sample.is_chroma))
    else $error("sample flags not carried");
  a_invert_swap: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sample.is_chroma && working.chroma_msb_invert && working.stored_byte_swap)
      |=> out_sample.data[15] != $past(in_sample.data[7]))
    else $error("chroma msb not inverted before swap");
  a_luma_untouched: assert property (@(posedge pclk) disable iff (!presetn)
      (!in_sample.is_chroma && !working.stored_byte_swap)
      |=> out_sample.data == $past(in_sample.data))
    else $error("luma sample altered");
endmodule
`default_nettype wire

/* File: bench/video_input_format_config_tb.sv */
// randomised register, latch and sample-path bench for the video input format block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module video_input_format_config_tb
  import vifc_pkg::*;
;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic  [11:0] paddr;
  logic  [31:0] pwdata;
  logic         pready;
  logic         pslverr;
  logic  [31:0] prdata;
  logic         internal_vsync;
  vifc_sample_t in_sample;
  vifc_sample_t out_sample;
  logic  [3:0]  lvl;
  logic  [31:0] r;
  logic  [31:0] w0;
  logic  [31:0] w1;
  logic  [31:0] k0;
  logic  [31:0] k1;
  logic  [31:0] tmp;
  logic         e;
  vifc_sample_t s;
  int           n_mismatch;
  int           compares;

  vifc_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .internal_vsync(internal_vsync), .in_sample(in_sample), .out_sample(out_sample),
    .embedded_sync_input_enable(lvl[3]), .timing_flag_correction_enable(lvl[2]),
    .embedded_sync_sample_width(lvl[1]), .luma_pixel_position(lvl[0])
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic vifc_sample_t exp_smp(vifc_sample_t x, logic [31:0] c);
    exp_smp = x;
    if (x.is_chroma && c[VIFC_BIT_MSB_INV]) exp_smp.data[7] = ~x.data[7];
    if (c[VIFC_BIT_BYTE_SWAP]) exp_smp.data = {exp_smp.data[7:0], exp_smp.data[15:8]};
  endfunction

  function automatic logic [3:0] exp_lvl(logic [31:0] i, logic [31:0] c);
    exp_lvl = {i[VIFC_BIT_INPUT_EN], i[VIFC_BIT_FLAG_CORR],
               c[VIFC_BIT_SAMPLE_W] & i[VIFC_BIT_INPUT_EN], c[VIFC_BIT_LUMA_POS]};
  endfunction

  initial
  begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(74698));
    {presetn, psel, penable, pwrite, internal_vsync} = '0;
    paddr = '0;
    pwdata = '0;
    in_sample = '0;
    k0 = '0;
    k1 = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, VIFC_ADDR_IFCTL, '0, r, e);
    `CHK(r, VIFC_RESET_VAL)
    apb(1'b0, VIFC_ADDR_CFG, '0, r, e);
    `CHK(r, VIFC_RESET_VAL)
    for (int i = 0; i < 6; i++)
    begin
      w0 = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      w1 = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      w1[VIFC_BIT_VSYNC_LC] = (i >= 3);
      apb(1'b1, VIFC_ADDR_IFCTL, w0, r, e);
      apb(1'b1, VIFC_ADDR_CFG, w1, r, e);
      apb(1'b0, VIFC_ADDR_IFCTL, '0, r, e);
      `CHK({e, r}, {1'b0, w0 & VIFC_IFCTL_MASK})
      apb(1'b0, VIFC_ADDR_CFG, '0, r, e);
      `CHK({e, r}, {1'b0, w1 & VIFC_CFG_MASK})
      if (i < 3)
      begin
        // settings must still be the old ones until the vsync pulse
        #1 `CHK(lvl, exp_lvl(k0, k1))
        @(posedge pclk);
        internal_vsync <= 1'b1;
        @(posedge pclk);
        internal_vsync <= 1'b0;
      end
      k0 = w0;
      k1 = w1;
      @(posedge pclk);
      #1 `CHK(lvl, exp_lvl(k0, k1))
      for (int j = 0; j < 4; j++)
      begin
        tmp = $urandom;
        s = tmp[17:0];
        s.valid = 1'b1;
        s.is_chroma = s.is_chroma | (j == 0);
        @(posedge pclk);
        in_sample <= s;
        @(posedge pclk);
        #1 `CHK(out_sample, exp_smp(s, k1))
      end
    end
    // unmapped space answers with an error and leaves the configuration register alone
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, r, e);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h008, '0, r, e);
    `CHK({e, r}, {1'b1, VIFC_ERR_DATA})
    apb(1'b0, VIFC_ADDR_CFG, '0, r, e);
    `CHK(r, k1 & VIFC_CFG_MASK)
    end_of_test();
  end
endmodule
`default_nettype wire
